// File: logic/dcfg_pkg.sv
package dcfg_pkg;

    // clock and time base
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned TEACH_HOLD_MS = 2000;
    localparam int unsigned FAULT_DELAY_MS = 1000;
    localparam int unsigned SECOND_MS = 1000;
    localparam int unsigned BLINK_HALF_MS = 250;
    localparam int unsigned FLASH_SHOW_MS = 3000;
    localparam int unsigned RSP_TIMEOUT_US = 200;
    localparam logic [31:0] TEACH_HOLD_CYC = 32'(TEACH_HOLD_MS * CYC_PER_MS);
    localparam logic [31:0] FAULT_DELAY_CYC = 32'(FAULT_DELAY_MS * CYC_PER_MS);
    localparam logic [31:0] SECOND_CYC = 32'(SECOND_MS * CYC_PER_MS);
    localparam logic [31:0] BLINK_HALF_CYC = 32'(BLINK_HALF_MS * CYC_PER_MS);
    localparam logic [31:0] FLASH_SHOW_CYC = 32'(FLASH_SHOW_MS * CYC_PER_MS);
    localparam logic [15:0] RSP_TIMEOUT_CYC = 16'((RSP_TIMEOUT_US * (CLK_HZ / 1000)) / 1000);
    localparam logic [11:0] SEC_PER_HOUR = 12'd3600;

    // process image
    localparam int unsigned NODES = 32;
    localparam int unsigned SLAVES = 31;
    localparam int unsigned NODE_W = 5;

    // register byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DIRECT = 8'h08;
    localparam logic [7:0] REG_VALID = 8'h0c;
    localparam logic [7:0] REG_CNT_BASE = 8'h10;
    localparam logic [7:0] REG_POWER_ON = 8'h2c;
    localparam logic [7:0] REG_HOURS = 8'h30;
    localparam int unsigned STAT_N = 7;

    // control register fields
    localparam int unsigned CTRL_TEACH = 0;
    localparam int unsigned CTRL_HOLD_POLL = 1;

    // status flag positions
    localparam int unsigned ST_BUS_ACTIVE = 0;
    localparam int unsigned ST_STARTUP_DONE = 1;
    localparam int unsigned ST_IN_STARTUP = 2;
    localparam int unsigned ST_MASTER_ERR = 3;
    localparam int unsigned ST_COMM_ERR = 4;
    localparam int unsigned ST_INIT_ERR = 5;
    localparam int unsigned ST_SHORT = 6;
    localparam int unsigned ST_TEACH_REQ = 7;

    // master diagnostics byte positions
    localparam int unsigned DG_FAULT = 0;
    localparam int unsigned DG_INIT_ERR = 4;
    localparam int unsigned DG_TEACH_ERR = 5;
    localparam int unsigned DG_SHORT = 6;
    localparam int unsigned DG_COMM_ERR = 7;

    localparam logic [7:0] DIRECT_NO_ANSWER = 8'hff;

    typedef enum logic [1:0] {
        DCFG_STARTUP,
        DCFG_POLL_REQ,
        DCFG_POLL_WAIT
    } dcfg_mode_t;

endpackage : dcfg_pkg

// File: logic/dcfg_gateway.sv
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ns

module dcfg_gateway
    import dcfg_pkg::*;
#(
    parameter logic [31:0] HOLD_CYC = TEACH_HOLD_CYC,
    parameter logic [31:0] FAULT_CYC = FAULT_DELAY_CYC,
    parameter logic [31:0] SEC_CYC = SECOND_CYC,
    parameter logic [31:0] BLINK_CYC = BLINK_HALF_CYC,
    parameter logic [31:0] FLASH_CYC = FLASH_SHOW_CYC,
    parameter logic [15:0] TIMEOUT_CYC = RSP_TIMEOUT_CYC
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    input wire logic [4:0] FB_ADDR,
    input wire logic [15:0] FB_WDATA,
    input wire logic FB_WR,
    input wire logic FB_RD,
    output logic [15:0] FB_RDATA,
    output logic CHAIN_REQ,
    output logic [4:0] CHAIN_REQ_NODE,
    output logic [7:0] CHAIN_REQ_BYTE,
    input wire logic CHAIN_RSP,
    input wire logic [7:0] CHAIN_RSP_STATUS,
    input wire logic [7:0] CHAIN_RSP_DIAG,
    input wire logic [7:0] CHAIN_RSP_TYPE,
    input wire logic CHAIN_READY,
    input wire logic CHAIN_INIT_FAIL,
    input wire logic [4:0] CHAIN_FOUND_CNT,
    input wire logic CHAIN_SHORT,
    input wire logic CHAIN_BYTE_TX,
    input wire logic CHAIN_BYTE_RX,
    input wire logic CHAIN_FRAME_TX,
    input wire logic CHAIN_FRAME_RX,
    input wire logic CHAIN_RETRY_OK,
    input wire logic CHAIN_RETRY_FAIL,
    input wire logic CHAIN_CRC_ERR,
    input wire logic TEACH_BUTTON_N,
    input wire logic [31:0] POWER_ON_COUNT_IN,
    input wire logic [31:0] HOUR_METER_IN,
    output logic [31:0] POWER_ON_COUNT,
    output logic FUNCTION_STATUS_LAMP,
    output logic [7:0] MASTER_DIAG
);

    typedef struct packed {
        logic [1:0] btn_sync;
        logic [1:0] short_sync;
        dcfg_mode_t mode;
        logic hold_poll;
        logic [4:0] node;
        logic [4:0] found;
        logic [15:0] wait_cnt;
        logic direct_pend;
        logic direct_active;
        logic [4:0] direct_node;
        logic [7:0] direct_byte;
        logic [7:0] direct_rsp;
        logic [NODES-1:0][15:0] out_img;
        logic [NODES-1:0][15:0] in_img;
        logic [SLAVES-1:0][7:0] det_type;
        logic [SLAVES-1:0][7:0] saved_type;
        logic [4:0] saved_cnt;
        logic [4:0] det_cnt;
        logic scan_mismatch;
        logic scan_timeout;
        logic [NODES-1:0] scan_valid;
        logic [NODES-1:0] valid;
        logic mismatch;
        logic comm_err;
        logic init_err;
        logic fault;
        logic [31:0] fault_cnt;
        logic [31:0] hold_cnt;
        logic hold_done;
        logic [31:0] flash_cnt;
        logic [31:0] blink_cnt;
        logic blink;
        logic req;
        logic [4:0] req_node;
        logic [7:0] req_byte;
        logic [STAT_N-1:0][31:0] stat;
        logic [31:0] pwr_cnt;
        logic [31:0] hours;
        logic [31:0] sec_cnt;
        logic [11:0] sec_in_hour;
        logic loaded;
        logic [31:0] rdata;
        logic [15:0] fb_rdata;
    } dcfg_regs_t;

    dcfg_regs_t st;
    dcfg_regs_t next_st;

    logic teach_req;
    logic teach_err;
    logic fault_raw;
    logic [7:0] diag;
    logic [7:0] flags;
    logic [NODES-1:0] valid_out;
    logic fault_on;
    logic direct_wr;

    function automatic logic [31:0] inc32(input logic [31:0] v, input logic en);
        inc32 = v + {31'h0, en};
    endfunction : inc32

    function automatic logic [31:0] rd_word(input logic [7:0] a, input dcfg_regs_t s, input logic [7:0] f,
                                           input logic [7:0] d, input logic [NODES-1:0] vm);
        logic [3:0] k;
        k = 4'(a[5:2] - REG_CNT_BASE[5:2]);
        rd_word = 32'h0;
        case (a)
            REG_CTRL: rd_word = {30'h0, s.hold_poll, 1'b0};
            REG_STATUS: rd_word = {3'h0, s.found, 3'h0, s.saved_cnt, d, f};
            REG_DIRECT: rd_word = {s.direct_pend, 7'h0, s.direct_rsp, s.direct_byte, 3'h0, s.direct_node};
            REG_VALID: rd_word = vm;
            REG_POWER_ON: rd_word = s.pwr_cnt;
            REG_HOURS: rd_word = s.hours;
            default: begin
                if (a >= REG_CNT_BASE && a < REG_POWER_ON && a[1:0] == 2'h0) begin
                    rd_word = s.stat[k[2:0]];
                end
            end
        endcase
    endfunction : rd_word

    assign teach_req = (st.saved_cnt == 5'h0) || st.mismatch;
    assign teach_err = st.mismatch && (st.saved_cnt != 5'h0);
    assign fault_raw = st.short_sync[1] || st.init_err || (st.comm_err && st.valid[NODES-1:1] == '0);
    assign fault_on = st.fault && fault_raw;
    assign direct_wr = REG_WR && REG_ADDR == REG_DIRECT;
    assign diag = {st.comm_err, st.short_sync[1], teach_err, st.init_err, 3'h0, fault_on};
    assign flags = {teach_req, st.short_sync[1], st.init_err, st.comm_err, fault_on,
                    st.mode == DCFG_STARTUP, st.mode != DCFG_STARTUP, st.mode != DCFG_STARTUP && !st.hold_poll};
    assign valid_out = fault_on ? {{(NODES-1){1'b0}}, 1'b1} : st.valid;

    always_comb begin
        next_st = st;
        next_st.req = 1'b0;
        next_st.btn_sync = {st.btn_sync[0], ~TEACH_BUTTON_N};
        next_st.short_sync = {st.short_sync[0], CHAIN_SHORT};

        if (!st.loaded) begin
            next_st.loaded = 1'b1;
            next_st.pwr_cnt = inc32(POWER_ON_COUNT_IN, 1'b1);
            next_st.hours = HOUR_METER_IN;
        end else if (st.sec_cnt >= SEC_CYC - 32'h1) begin
            next_st.sec_cnt = 32'h0;
            if (st.sec_in_hour >= SEC_PER_HOUR - 12'h1) begin
                next_st.sec_in_hour = 12'h0;
                next_st.hours = inc32(st.hours, 1'b1);
            end else begin
                next_st.sec_in_hour = st.sec_in_hour + 12'h1;
            end
        end else begin
            next_st.sec_cnt = inc32(st.sec_cnt, 1'b1);
        end

        next_st.stat[0] = inc32(st.stat[0], CHAIN_BYTE_TX);
        next_st.stat[1] = inc32(st.stat[1], CHAIN_BYTE_RX);
        next_st.stat[2] = inc32(st.stat[2], CHAIN_FRAME_TX);
        next_st.stat[3] = inc32(st.stat[3], CHAIN_FRAME_RX);
        next_st.stat[4] = inc32(st.stat[4], CHAIN_RETRY_OK);
        next_st.stat[5] = inc32(st.stat[5], CHAIN_RETRY_FAIL);
        next_st.stat[6] = inc32(st.stat[6], CHAIN_CRC_ERR);

        if (CHAIN_INIT_FAIL) begin
            next_st.init_err = 1'b1;
        end

        if (!fault_raw) begin
            next_st.fault_cnt = 32'h0;
            next_st.fault = 1'b0;
        end else if (st.fault_cnt >= FAULT_CYC - 32'h1) begin
            next_st.fault = 1'b1;
        end else begin
            next_st.fault_cnt = inc32(st.fault_cnt, 1'b1);
        end

        // field bus side: out image written by the master, in image read back
        // two-byte words each way
        if (FB_WR) begin
            next_st.out_img[FB_ADDR] = FB_WDATA;
        end
        if (FB_RD) begin
            next_st.fb_rdata = (FB_ADDR == 5'h0) ? {st.direct_rsp, diag} : st.in_img[FB_ADDR];
        end

        if (REG_RD) begin
            next_st.rdata = rd_word(REG_ADDR, st, flags, diag, valid_out);
        end
        if (REG_WR && REG_ADDR == REG_CTRL) begin
            next_st.hold_poll = REG_WDATA[CTRL_HOLD_POLL];
        end
        if (REG_WR && REG_ADDR == REG_DIRECT) begin
            next_st.direct_node = REG_WDATA[4:0];
            next_st.direct_byte = REG_WDATA[15:8];
            next_st.direct_pend = 1'b1;
        end

        if (!st.btn_sync[1]) begin
            next_st.hold_cnt = 32'h0;
            next_st.hold_done = 1'b0;
        end else if (!st.hold_done) begin
            next_st.hold_cnt = inc32(st.hold_cnt, 1'b1);
            if (st.hold_cnt >= HOLD_CYC - 32'h1) begin
                next_st.hold_done = 1'b1;
            end
        end

        if ((st.btn_sync[1] && !st.hold_done && st.hold_cnt >= HOLD_CYC - 32'h1) ||
            (REG_WR && REG_ADDR == REG_CTRL && REG_WDATA[CTRL_TEACH])) begin
            if (st.det_cnt != 5'h0) begin
                next_st.saved_type = st.det_type;
                next_st.saved_cnt = st.det_cnt;
                next_st.mismatch = 1'b0;
                // compares made against the old setup are void
                next_st.scan_mismatch = 1'b0;
                next_st.flash_cnt = FLASH_CYC;
            end
        end else if (st.flash_cnt != 32'h0) begin
            next_st.flash_cnt = st.flash_cnt - 32'h1;
        end

        if (st.blink_cnt >= BLINK_CYC - 32'h1) begin
            next_st.blink_cnt = 32'h0;
            next_st.blink = ~st.blink;
        end else begin
            next_st.blink_cnt = inc32(st.blink_cnt, 1'b1);
        end

        case (st.mode)
            DCFG_STARTUP: begin
                next_st.node = 5'h1;
                if (CHAIN_READY && !st.init_err) begin
                    next_st.mode = DCFG_POLL_REQ;
                    next_st.found = CHAIN_FOUND_CNT;
                end
            end
            DCFG_POLL_REQ: begin
                if (!CHAIN_READY) begin
                    next_st.mode = DCFG_STARTUP;
                end else if (!st.hold_poll && st.found != 5'h0) begin
                    next_st.req = 1'b1;
                    next_st.req_node = st.node;
                    next_st.wait_cnt = 16'h0;
                    next_st.mode = DCFG_POLL_WAIT;
                    if (st.direct_pend && st.direct_node == st.node) begin
                        next_st.req_byte = st.direct_byte;
                        next_st.direct_active = 1'b1;
                    end else begin
                        next_st.req_byte = st.out_img[st.node][7:0];
                    end
                end else if (st.found == 5'h0) begin
                    next_st.found = CHAIN_FOUND_CNT;
                end
            end
            DCFG_POLL_WAIT: begin
                if (CHAIN_RSP || st.wait_cnt >= TIMEOUT_CYC - 16'h1) begin
                    if (CHAIN_RSP) begin
                        next_st.in_img[st.node] = {CHAIN_RSP_DIAG, CHAIN_RSP_STATUS};
                        next_st.det_type[st.node - 5'h1] = CHAIN_RSP_TYPE;
                        next_st.scan_valid[st.node] = 1'b1;
                        if (st.saved_cnt != 5'h0 && CHAIN_RSP_TYPE != st.saved_type[st.node - 5'h1]) begin
                            next_st.scan_mismatch = 1'b1;
                        end
                        if (st.direct_active) begin
                            next_st.direct_rsp = CHAIN_RSP_STATUS;
                        end
                    end else begin
                        next_st.scan_valid[st.node] = 1'b0;
                        next_st.scan_timeout = 1'b1;
                        if (st.direct_active) begin
                            next_st.direct_rsp = DIRECT_NO_ANSWER;
                        end
                    end
                    if (st.direct_active) begin
                        next_st.direct_active = 1'b0;
                        // a command written in this cycle stays pending
                        next_st.direct_pend = direct_wr;
                    end
                    next_st.mode = DCFG_POLL_REQ;
                    if (st.node >= st.found) begin
                        next_st.node = 5'h1;
                        next_st.valid = next_st.scan_valid | {{(NODES-1){1'b0}}, 1'b1};
                        next_st.scan_valid = '0;
                        next_st.comm_err = next_st.scan_timeout;
                        next_st.scan_timeout = 1'b0;
                        next_st.det_cnt = st.found;
                        next_st.mismatch = next_st.scan_mismatch ||
                                           (st.saved_cnt != 5'h0 && st.found != st.saved_cnt);
                        next_st.scan_mismatch = 1'b0;
                        next_st.found = CHAIN_FOUND_CNT;
                        if (st.direct_pend && !st.direct_active && !direct_wr &&
                            (st.direct_node == 5'h0 || st.direct_node > st.found)) begin
                            next_st.direct_pend = 1'b0;
                            next_st.direct_rsp = DIRECT_NO_ANSWER;
                        end
                    end else begin
                        next_st.node = st.node + 5'h1;
                    end
                end else begin
                    next_st.wait_cnt = st.wait_cnt + 16'h1;
                end
            end
            default: begin
                next_st.mode = DCFG_STARTUP;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st <= '0;
        end else if (CE) begin
            st <= next_st;
        end
    end

    assign REG_RDATA = st.rdata;
    assign FB_RDATA = st.fb_rdata;
    assign CHAIN_REQ = st.req;
    assign CHAIN_REQ_NODE = st.req_node;
    assign CHAIN_REQ_BYTE = st.req_byte;
    assign POWER_ON_COUNT = st.pwr_cnt;
    assign MASTER_DIAG = diag;
    assign FUNCTION_STATUS_LAMP = (st.flash_cnt != 32'h0 || teach_req) ? st.blink : (st.found == 5'h0);

endmodule : dcfg_gateway

// File: bench/dcfg_chain_model.sv
`timescale 1ns/1ns
module dcfg_chain_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req,
    input wire logic [4:0] req_node,
    input wire logic [7:0] req_byte,
    input wire logic [4:0] mute_node,
    input wire logic [7:0] type_ofs,
    output logic rsp,
    output logic [7:0] rsp_status,
    output logic [7:0] rsp_diag,
    output logic [7:0] rsp_type,
    output logic ready,
    output logic [4:0] found
);
    logic [2:0] wait_cnt;
    logic [4:0] node;
    logic [7:0] byte_q;
    assign found = 5'h3;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt <= 3'h0;
            rsp <= 1'b0;
            ready <= 1'b0;
            rsp_status <= 8'h00;
            rsp_diag <= 8'h00;
            rsp_type <= 8'h00;
        end else begin
            ready <= 1'b1;
            rsp <= 1'b0;
            // reply fields are only meaningful beside the pulse
            rsp_status <= ~rsp_status;
            rsp_diag <= ~rsp_diag;
            rsp_type <= ~rsp_type;
            // reply per node: odd nodes answer fast, even nodes slow
            if (req && req_node != mute_node) begin
                node <= req_node;
                byte_q <= req_byte;
                wait_cnt <= req_node[0] ? 3'h1 : 3'h4;
            end else if (wait_cnt == 3'h1) begin
                wait_cnt <= 3'h0;
                rsp <= 1'b1;
                rsp_status <= byte_q;
                rsp_diag <= {3'h0, node};
                rsp_type <= 8'h30 + {3'h0, node} + type_ofs;
            end else if (wait_cnt != 3'h0) begin
                wait_cnt <= wait_cnt - 3'h1;
            end
        end
    end
endmodule : dcfg_chain_model

// File: bench/dcfg_gateway_assertions.sv
`timescale 1ns/1ns
module dcfg_gateway_assertions
    import dcfg_pkg::*;
#(
    parameter logic [31:0] FAULT_CYC = FAULT_DELAY_CYC
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic CHAIN_SHORT,
    input wire logic CHAIN_REQ,
    input wire logic [4:0] CHAIN_REQ_NODE,
    input wire logic FB_RD,
    input wire logic [15:0] FB_RDATA,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic [31:0] POWER_ON_COUNT_IN,
    input wire logic [31:0] POWER_ON_COUNT,
    input wire logic [7:0] MASTER_DIAG
);
    logic [31:0] cause_run;
    logic [1:0] up_cnt;
    wire cause = MASTER_DIAG[DG_INIT_ERR] | MASTER_DIAG[DG_SHORT] | MASTER_DIAG[DG_COMM_ERR];
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cause_run <= 32'h0;
            up_cnt <= 2'h0;
        end else if (CE) begin
            cause_run <= cause ? cause_run + 32'h1 : 32'h0;
            up_cnt <= (up_cnt == 2'h2) ? up_cnt : up_cnt + 2'h1;
        end
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    sequence short_held;
        (CE && CHAIN_SHORT) [*5];
    endsequence
    diag_unused_zero_a: assert property (MASTER_DIAG[3:1] == 3'h0)
        else $error("unused diag bits not zero");
    short_flag_a: assert property (short_held |-> MASTER_DIAG[DG_SHORT])
        else $error("short not flagged");
    init_sticky_a: assert property (MASTER_DIAG[DG_INIT_ERR] |=> MASTER_DIAG[DG_INIT_ERR])
        else $error("init error flag dropped");
    fault_cause_a: assert property (MASTER_DIAG[DG_FAULT] |-> cause)
        else $error("fault flag without cause");
    fault_delay_a: assert property ($rose(MASTER_DIAG[DG_FAULT]) |-> cause_run >= FAULT_CYC - 32'h1)
        else $error("fault flag too early");
    req_pulse_a: assert property (CHAIN_REQ |=> !CHAIN_REQ)
        else $error("poll request longer than one cycle");
    req_slave_node_a: assert property (CHAIN_REQ |-> CHAIN_REQ_NODE != 5'h00)
        else $error("poll sent to gateway position");
    fb_data_hold_a: assert property (!FB_RD |=> $stable(FB_RDATA))
        else $error("field bus data changed without read");
    reg_data_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
        else $error("register data changed without read");
    power_count_a: assert property (up_cnt == 2'h2 |-> POWER_ON_COUNT == POWER_ON_COUNT_IN + 32'h1)
        else $error("power-on count not incremented");
endmodule : dcfg_gateway_assertions
bind dcfg_gateway dcfg_gateway_assertions #(.FAULT_CYC(FAULT_CYC)) dcfg_gateway_assertions_i (
    .CLK(CLK), .RST_N(RST_N), .CE(CE), .CHAIN_SHORT(CHAIN_SHORT), .CHAIN_REQ(CHAIN_REQ),
    .CHAIN_REQ_NODE(CHAIN_REQ_NODE), .FB_RD(FB_RD), .FB_RDATA(FB_RDATA), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .POWER_ON_COUNT_IN(POWER_ON_COUNT_IN), .POWER_ON_COUNT(POWER_ON_COUNT),
    .MASTER_DIAG(MASTER_DIAG)
);

// File: bench/dcfg_gateway_tb.sv
`timescale 1ns/1ns
module dcfg_gateway_tb
    import dcfg_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, fb_wr = 1'b0, fb_rd = 1'b0;
    logic short = 1'b0, init_fail = 1'b0, button_n = 1'b1, ce = 1'b1, l0;
    logic chain_req, chain_rsp, chain_ready, lamp;
    logic [7:0] reg_addr = 8'h00, type_ofs = 8'h00, req_byte, rsp_status, rsp_diag, rsp_type, diag;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, power_cnt, pwr_in = 32'h11, hour_in = 32'h5;
    logic [15:0] fb_wdata = 16'h0, fb_rdata, fd;
    logic [4:0] fb_addr = 5'h0, mute_node = 5'h1f, req_node, found, n;
    logic [6:0] stat = 7'h0;
    int error_cnt = 0, compares = 0;
    dcfg_gateway #(.HOLD_CYC(32'h14), .FAULT_CYC(32'ha), .SEC_CYC(32'h5), .BLINK_CYC(32'h2),
        .FLASH_CYC(32'h1e), .TIMEOUT_CYC(16'h8)) dcfg_gateway_i (
        .CLK(clk), .RST_N(rst_n), .CE(ce), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .FB_ADDR(fb_addr), .FB_WDATA(fb_wdata),
        .FB_WR(fb_wr), .FB_RD(fb_rd), .FB_RDATA(fb_rdata), .CHAIN_REQ(chain_req), .CHAIN_REQ_NODE(req_node),
        .CHAIN_REQ_BYTE(req_byte), .CHAIN_RSP(chain_rsp), .CHAIN_RSP_STATUS(rsp_status),
        .CHAIN_RSP_DIAG(rsp_diag), .CHAIN_RSP_TYPE(rsp_type), .CHAIN_READY(chain_ready),
        .CHAIN_INIT_FAIL(init_fail), .CHAIN_FOUND_CNT(found), .CHAIN_SHORT(short),
        .CHAIN_BYTE_TX(stat[0]), .CHAIN_BYTE_RX(stat[1]), .CHAIN_FRAME_TX(stat[2]), .CHAIN_FRAME_RX(stat[3]),
        .CHAIN_RETRY_OK(stat[4]), .CHAIN_RETRY_FAIL(stat[5]), .CHAIN_CRC_ERR(stat[6]),
        .TEACH_BUTTON_N(button_n), .POWER_ON_COUNT_IN(pwr_in), .HOUR_METER_IN(hour_in),
        .POWER_ON_COUNT(power_cnt), .FUNCTION_STATUS_LAMP(lamp), .MASTER_DIAG(diag));
    dcfg_chain_model dcfg_chain_model_i (.clk(clk), .rst_n(rst_n), .req(chain_req), .req_node(req_node),
        .req_byte(req_byte), .mute_node(mute_node), .type_ofs(type_ofs), .rsp(chain_rsp),
        .rsp_status(rsp_status), .rsp_diag(rsp_diag), .rsp_type(rsp_type), .ready(chain_ready), .found(found));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : tick
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_wr_t
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        cmp(reg_rdata & mask, exp);
    endtask : chk_reg
    task automatic fb_wr_t(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        fb_addr <= a;
        fb_wdata <= d;
        fb_wr <= 1'b1;
        @(posedge clk);
        fb_wr <= 1'b0;
    endtask : fb_wr_t
    task automatic fb_rd_t(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        fb_addr <= a;
        fb_rd <= 1'b1;
        @(posedge clk);
        fb_rd <= 1'b0;
        @(posedge clk);
        d = fb_rdata;
    endtask : fb_rd_t
    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    initial begin
        tick(20);
        rst_n <= 1'b1;
        tick(40);
        chk_reg(REG_STATUS, 32'h80, 32'h80);
        reg_wr_t(REG_CTRL, 32'h1);
        tick(20);
        l0 = lamp;
        tick(2);
        cmp({31'h0, lamp}, {31'h0, ~l0});
        tick(30);
        cmp({31'h0, lamp}, 32'h0);
        chk_reg(REG_STATUS, 32'h0003_0000, 32'h001f_0080);
        $display("test teach by register done");
        for (n = 5'h1; n < 5'h4; n++) fb_wr_t(n, {8'h00, 8'h50 + {3'h0, n}});
        tick(40);
        for (n = 5'h1; n < 5'h4; n++) begin
            fb_rd_t(n, fd);
            cmp({16'h0, fd}, {16'h0, 3'h0, n, 8'h50 + {3'h0, n}});
        end
        fb_rd_t(5'h14, fd);
        cmp({16'h0, fd}, 32'h0);
        reg_wr_t(REG_DIRECT, 32'h0000_a502);
        tick(30);
        chk_reg(REG_DIRECT, 32'h00a5_a502, 32'h80ff_ff1f);
        fb_rd_t(5'h0, fd);
        cmp({16'h0, fd}, 32'h0000_a500);
        $display("test process image done");
        type_ofs <= 8'h01;
        tick(40);
        cmp({24'h0, diag & 8'h20}, 32'h20);
        button_n <= 1'b0;
        tick(10);
        button_n <= 1'b1;
        tick(30);
        chk_reg(REG_STATUS, 32'h80, 32'h80);
        button_n <= 1'b0;
        tick(30);
        button_n <= 1'b1;
        tick(40);
        chk_reg(REG_STATUS, 32'h0, 32'h2080);
        $display("test teach button done");
        reg_wr_t(REG_CTRL, 32'h2);
        tick(20);
        chk_reg(REG_CTRL, 32'h2, 32'h3);
        chk_reg(REG_STATUS, 32'h2, 32'h7);
        // first pass runs with the clock enable low and must not count
        for (int k = 0; k < 2; k++) begin
            ce <= (k == 1);
            for (int i = 0; i < 8; i++) begin
                @(posedge clk);
                stat <= 7'h7f >> i;
            end
        end
        reg_wr_t(REG_CTRL, 32'h0);
        reg_wr_t(8'h40, 32'hffff_ffff);
        reg_wr_t(REG_POWER_ON, 32'h0);
        for (int j = 0; j < 7; j++) chk_reg(REG_CNT_BASE + 8'(4 * j), 32'(7 - j), 32'hffff_ffff);
        chk_reg(REG_POWER_ON, 32'h12, 32'hffff_ffff);
        cmp(power_cnt, 32'h12);
        chk_reg(REG_HOURS, 32'h5, 32'hffff_ffff);
        chk_reg(8'h40, 32'h0, 32'hffff_ffff);
        $display("test counters done");
        mute_node <= 5'h2;
        tick(60);
        cmp({24'h0, diag & 8'h80}, 32'h80);
        chk_reg(REG_VALID, 32'hb, 32'hffff_ffff);
        mute_node <= 5'h1f;
        tick(60);
        cmp({24'h0, diag}, 32'h0);
        short <= 1'b1;
        tick(8);
        cmp({24'h0, diag & 8'h41}, 32'h40);
        tick(12);
        cmp({24'h0, diag & 8'h41}, 32'h41);
        chk_reg(REG_VALID, 32'h1, 32'hffff_ffff);
        chk_reg(REG_STATUS, 32'h48, 32'h48);
        short <= 1'b0;
        tick(6);
        cmp({24'h0, diag & 8'h41}, 32'h0);
        $display("test faults done");
        @(posedge clk);
        init_fail <= 1'b1;
        @(posedge clk);
        init_fail <= 1'b0;
        tick(80);
        cmp({24'h0, diag & 8'h10}, 32'h10);
        rst_n <= 1'b0;
        pwr_in <= 32'h20;
        hour_in <= 32'h9;
        tick(20);
        rst_n <= 1'b1;
        tick(40);
        cmp({24'h0, diag}, 32'h0);
        cmp(power_cnt, 32'h21);
        chk_reg(REG_HOURS, 32'h9, 32'hffff_ffff);
        chk_reg(REG_STATUS, 32'h80, 32'h80);
        $display("test init error done");
        complete_run();
    end
    initial begin
        repeat (6000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
endmodule : dcfg_gateway_tb
